// *** rtl/flb_pkg.sv ***
/*
 Shared constants for the flash bus host: pin widths, operation codes,
 protect-select address bits and cycle timing derived from ref_clk.
 Assumes a 40 MHz ref_clk; change CLK_PERIOD_NS if the clock changes.
*/
package flb_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int ADDR_W = 20;
   localparam int PIN_ADDR_W = 19;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 16;
   // select/address access time, least wait before sampling data
   localparam int ACC_NS = 70;
   localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_PULSE_NS = 35;
   localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_HIGH_NS = 20;
   localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_LOW_NS = 500;
   localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_HIGH_NS = 50;
   localparam int RST_HIGH_CYC = (RST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_READY_NS = 20000;
   localparam int RST_READY_CYC = RST_READY_NS / CLK_PERIOD_NS;
   localparam int BUSY_SETTLE_NS = 90;
   localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // address pins forced during in-system protect
   localparam int PROT_SEL_BIT = 6;
   localparam int PROT_A1_BIT = 1;
   localparam int PROT_A0_BIT = 0;
   localparam logic [2:0] PROG_WRITES = 3'h4;
   localparam logic [2:0] BYP_WRITES = 3'h2;
   localparam logic [2:0] ERASE_LAST = 3'h5;
   localparam logic [7:0] HIGH_CNT_RST = 8'hFF;

   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_CMD = 4'h1,
      OP_PROG = 4'h2,
      OP_BYP_ENTER = 4'h3,
      OP_BYP_PROG = 4'h4,
      OP_BYP_EXIT = 4'h5,
      OP_SECT_ERASE = 4'h6,
      OP_CHIP_ERASE = 4'h7,
      OP_AUTOSEL = 4'h8,
      OP_RESET = 4'h9,
      OP_PROTECT = 4'hA,
      OP_HV_ID = 4'hB
   } flb_op_e;
endpackage : flb_pkg

// *** rtl/flb_cycle.sv ***
/*
 One asynchronous flash bus cycle, read or write, timed in ref_clk cycles.
 Assumes dq_i is synchronous to ref_clk and the caller starts only when idle.
*/
module flb_cycle (
   // system
   input wire logic ref_clk,
   input wire logic rst,
   // cycle request
   input wire logic start,
   input wire logic wr,
   input wire logic byte_mode,
   input wire logic [flb_pkg::ADDR_W-1:0] addr,
   input wire logic [flb_pkg::DATA_W-1:0] wdata,
   output logic done_q,
   output logic [flb_pkg::DATA_W-1:0] rdata_q,
   // flash pins
   output logic [flb_pkg::PIN_ADDR_W-1:0] addr_q,
   output logic [flb_pkg::DATA_W-1:0] dq_o_q,
   output logic [flb_pkg::DATA_W-1:0] dq_oe_q,
   input wire logic [flb_pkg::DATA_W-1:0] dq_i,
   output logic cs_n_q,
   output logic oe_n_q,
   output logic we_n_q
);
   import flb_pkg::*;

   typedef enum logic [1:0] {
      C_IDLE = 2'h0,
      C_STROBE = 2'h1,
      C_RECOVER = 2'h2
   } flb_cyc_e;

   flb_cyc_e st_q;
   logic wr_q;
   logic [7:0] cnt_q;
   logic [DATA_W-1:0] oe_mask;

   // byte mode: top line carries the byte address, 8..14 float
   genvar b;
   generate
      for (b = 0; b < DATA_W; b++) begin : g_mask
         if (b < BYTE_W) begin : g_lo
            assign oe_mask[b] = wr;
         end else if (b == DATA_W - 1) begin : g_top
            assign oe_mask[b] = wr | byte_mode; // RL5
         end else begin : g_mid
            assign oe_mask[b] = wr & ~byte_mode; // RL5 RL11
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= C_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         cnt_q <= cnt_q + 8'h01;
         case (st_q)
            C_IDLE: begin
               if (start) begin
                  st_q <= C_STROBE;
                  wr_q <= wr;
                  cnt_q <= 8'h00;
               end
            end
            C_STROBE: begin
               if ((wr_q && cnt_q == 8'(WE_PULSE_CYC)) || (!wr_q && cnt_q == 8'(ACC_CYC))) begin
                  st_q <= C_RECOVER;
                  cnt_q <= 8'h00;
               end
            end
            C_RECOVER: begin
               if (cnt_q == 8'(WE_HIGH_CYC - 1)) begin
                  st_q <= C_IDLE;
                  done_q <= 1'b1;
               end
            end
            default: st_q <= C_IDLE;
         endcase
      end
   end

   // pins: chip select leads the strobe by one cycle, data held past we rise
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_q <= '0;
         dq_o_q <= '0;
         dq_oe_q <= '0;
         cs_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
      end else if (st_q == C_IDLE && start) begin
         cs_n_q <= 1'b0;
         addr_q <= byte_mode ? addr[ADDR_W-1:1] : addr[PIN_ADDR_W-1:0];
         dq_o_q <= byte_mode ? {addr[0], 7'h00, wdata[BYTE_W-1:0]} : wdata; // RL5
         dq_oe_q <= oe_mask;
      end else if (st_q == C_STROBE && cnt_q == 8'h00) begin
         oe_n_q <= wr_q; // RL2
         we_n_q <= ~wr_q; // RL10
      end else if (st_q == C_STROBE && cnt_q != 8'h00) begin
         if ((wr_q && cnt_q == 8'(WE_PULSE_CYC)) || (!wr_q && cnt_q == 8'(ACC_CYC))) begin
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
         end
      end else if (st_q == C_RECOVER && cnt_q == 8'(WE_HIGH_CYC - 1)) begin
         cs_n_q <= 1'b1;
         dq_oe_q <= '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (st_q == C_STROBE && !wr_q && cnt_q == 8'(ACC_CYC)) begin
         rdata_q <= dq_oe_q[DATA_W-2] ? dq_i : (dq_oe_q[DATA_W-1] ? {8'h00, dq_i[BYTE_W-1:0]} : dq_i);
      end
   end

   write_strobe_a: assert property (@(posedge ref_clk) disable iff (rst) // RL10
      !we_n_q |-> !cs_n_q && oe_n_q) else $error("write strobe without select or with gate low");
   read_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // RL2
      !oe_n_q |-> !cs_n_q && we_n_q) else $error("output gate low outside a read");
endmodule : flb_cycle

// *** rtl/flb_host.sv ***
/*
 Host controller for a boot-sector NOR flash: runs read, command, program,
 bypass, erase, identification, reset and protect sequences on the pins.
 Assumes pin inputs are synchronous to ref_clk and the board turns
 clear_vid_en / hv_pin_en into the elevated voltage on the named pins.
*/
// How it works
// RL1 - device starts in read-array mode after power-up or hardware reset.
// RL2 - reads hold select and output gate low, write strobe high.
// RL3 - device keeps returning array data until a command sequence changes mode.
// RL4 - width select high gives word mode on all sixteen data lines.
// RL5 - width select low: low byte only, lines 8-14 float, top line is byte address.
// RL6 - deselected device keeps its outputs floating whatever the output gate does.
// RL7 - program or erase continues to completion when select is released.
// RL8 - device sleeps when addresses stay stable for access time plus 30ns.
// RL9 - a read from standby needs only the normal select access time.
// RL10 - command writes drive write strobe and select low, output gate high.
// RL11 - program data goes as bytes or words according to width select.
// RL12 - normal program is two unlocks, a set-up, then address and data.
// RL13 - unlock-bypass program needs just two write cycles.
// RL14 - erase targets one sector, several sectors, or the whole array; the host issues only one-sector or whole-array erase.
// RL15 - autoselect command lets identification codes be read on the low byte.
// RL16 - identification gives maker, device and protect codes; command or high voltage.
// RL17 - clear pulse held low for the minimum; device aborts and ignores cycles.
// RL18 - an operation cut short by reset is issued again afterwards.
// RL19 - after reset during program or erase, busy stays low until reset completes.
// RL20 - host waits the release delay after clear rises before reading.
// RL21 - device refuses program or erase in a protected sector.
// RL22 - protect selected with elevated clear, select bit 0, A1 1, A0 0, then verify.
module flb_host #(
   parameter int PROT_PULSE_US = 150,
   parameter int PROT_PULSE_CYC = PROT_PULSE_US * 1000 / flb_pkg::CLK_PERIOD_NS,
   parameter logic [flb_pkg::ADDR_W-1:0] CMD_ADDR_A = 20'h00001,
   parameter logic [flb_pkg::ADDR_W-1:0] CMD_ADDR_B = 20'h00002,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_UNLOCK_A = 16'h0001,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_UNLOCK_B = 16'h0002,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_PROG = 16'h0003,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_BYP_ENTER = 16'h0004,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_BYP_EXIT1 = 16'h0005,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_BYP_EXIT2 = 16'h0006,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_ERASE_SETUP = 16'h0007,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_SECT_ERASE = 16'h0008,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_CHIP_ERASE = 16'h0009,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_AUTOSEL = 16'h000A,
   parameter logic [flb_pkg::DATA_W-1:0] CMD_PROTECT = 16'h000B
) (
   // system
   input wire logic ref_clk,
   input wire logic rst,
   // user requests
   input wire logic req_valid,
   input wire flb_pkg::flb_op_e req_op,
   input wire logic [flb_pkg::ADDR_W-1:0] req_addr,
   input wire logic [flb_pkg::DATA_W-1:0] req_data,
   input wire logic req_byte,
   input wire logic abort_req,
   output logic req_ready_q,
   output logic resp_valid_q,
   output logic [flb_pkg::DATA_W-1:0] resp_data_q,
   // flash pins
   output logic [flb_pkg::PIN_ADDR_W-1:0] flash_addr,
   output logic [flb_pkg::DATA_W-1:0] dq_o,
   output logic [flb_pkg::DATA_W-1:0] dq_oe,
   input wire logic [flb_pkg::DATA_W-1:0] dq_i,
   output logic chip_select_n,
   output logic output_gate_n,
   output logic write_strobe_n,
   output logic width_select_n_q,
   output logic device_clear_n_q,
   output logic clear_vid_en_q,
   output logic hv_pin_en_q,
   input wire logic ready_busy_n
);
   import flb_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ISSUE = 4'h1,
      S_WAIT_CYC = 4'h2,
      S_PULSE = 4'h3,
      S_SETTLE = 4'h4,
      S_BUSY = 4'h5,
      S_RST_LOW = 4'h6,
      S_RST_HIGH = 4'h7,
      S_RST_READY = 4'h8
   } flb_state_e;

   flb_state_e state_q;
   flb_op_e op_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic [2:0] step_q;
   logic [CNT_W-1:0] cnt_q;
   logic redo_q;
   logic start_q;
   logic cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   logic st_rd;
   logic st_last;
   logic [ADDR_W-1:0] st_addr;
   logic [DATA_W-1:0] st_data;
   logic waits_busy;
   logic [ADDR_W-1:0] prot_addr;

   // each sequence is a list of steps indexed by step_q
   always_comb begin
      st_rd = 1'b0;
      st_last = 1'b0;
      st_addr = CMD_ADDR_A;
      st_data = CMD_UNLOCK_A;
      prot_addr = addr_q;
      prot_addr[PROT_SEL_BIT + int'(width_select_n_q == 1'b0)] = 1'b0; // RL22
      prot_addr[PROT_A1_BIT + int'(width_select_n_q == 1'b0)] = 1'b1;
      prot_addr[PROT_A0_BIT + int'(width_select_n_q == 1'b0)] = 1'b0;
      if (step_q == 3'h1 || step_q == 3'h4) begin
         st_addr = CMD_ADDR_B;
         st_data = CMD_UNLOCK_B;
      end
      case (op_q)
         OP_CMD: begin
            st_last = 1'b1;
            st_addr = addr_q;
            st_data = data_q;
         end
         OP_PROG: begin // RL12
            if (step_q == 3'h2) st_data = CMD_PROG;
            if (step_q == 3'h3) begin
               st_last = 1'b1;
               st_addr = addr_q;
               st_data = data_q; // RL11
            end
         end
         OP_BYP_ENTER: begin
            if (step_q == 3'h2) begin
               st_last = 1'b1;
               st_data = CMD_BYP_ENTER;
            end
         end
         OP_BYP_PROG: begin // RL13
            st_data = CMD_PROG;
            if (step_q == 3'h1) begin
               st_last = 1'b1;
               st_addr = addr_q;
               st_data = data_q;
            end
         end
         OP_BYP_EXIT: begin
            st_addr = CMD_ADDR_A;
            st_data = (step_q == 3'h0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2;
            st_last = (step_q == 3'h1);
         end
         OP_SECT_ERASE, OP_CHIP_ERASE: begin // RL14
            if (step_q == 3'h2) st_data = CMD_ERASE_SETUP;
            if (step_q == ERASE_LAST) begin
               st_last = 1'b1;
               st_addr = (op_q == OP_SECT_ERASE) ? addr_q : CMD_ADDR_A;
               st_data = (op_q == OP_SECT_ERASE) ? CMD_SECT_ERASE : CMD_CHIP_ERASE;
            end
         end
         OP_AUTOSEL: begin // RL15
            if (step_q == 3'h2) st_data = CMD_AUTOSEL;
            if (step_q == 3'h3) begin
               st_rd = 1'b1;
               st_last = 1'b1;
               st_addr = addr_q;
            end
         end
         OP_PROTECT: begin // RL22
            st_addr = prot_addr;
            st_data = CMD_PROTECT;
            st_rd = (step_q == 3'h1);
            st_last = (step_q == 3'h1);
         end
         default: begin // plain read, high-voltage identification read
            st_rd = 1'b1;
            st_last = 1'b1;
            st_addr = addr_q;
         end
      endcase
   end

   assign waits_busy = (op_q == OP_PROG) || (op_q == OP_BYP_PROG) || (op_q == OP_SECT_ERASE) ||
      (op_q == OP_CHIP_ERASE);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= S_IDLE;
         op_q <= OP_READ;
         addr_q <= '0;
         data_q <= '0;
         step_q <= 3'h0;
         cnt_q <= '0;
         redo_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         cnt_q <= cnt_q + 16'h0001;
         case (state_q)
            S_IDLE: begin
               if (req_valid) begin
                  op_q <= req_op;
                  addr_q <= req_addr;
                  data_q <= req_data;
                  step_q <= 3'h0;
                  cnt_q <= '0;
                  state_q <= (req_op == OP_RESET) ? S_RST_LOW : S_ISSUE;
               end
            end
            S_ISSUE: begin
               start_q <= 1'b1;
               state_q <= S_WAIT_CYC;
            end
            S_WAIT_CYC: begin
               cnt_q <= '0;
               if (cyc_done) begin
                  if (st_last) state_q <= waits_busy ? S_SETTLE : S_IDLE;
                  else if (op_q == OP_PROTECT) state_q <= S_PULSE;
                  else state_q <= S_ISSUE;
                  if (!st_last) step_q <= step_q + 3'h1;
               end
            end
            S_PULSE: if (cnt_q == CNT_W'(PROT_PULSE_CYC - 1)) state_q <= S_ISSUE;
            S_SETTLE: if (cnt_q == CNT_W'(BUSY_SETTLE_CYC - 1)) state_q <= S_BUSY;
            S_BUSY: begin // RL7
               cnt_q <= '0;
               if (abort_req) begin
                  redo_q <= 1'b1; // RL18
                  state_q <= S_RST_LOW;
               end else if (ready_busy_n) begin
                  state_q <= S_IDLE;
               end
            end
            S_RST_LOW: begin
               if (cnt_q == CNT_W'(RST_LOW_CYC - 1)) begin // RL17
                  state_q <= S_RST_HIGH;
                  cnt_q <= '0;
               end
            end
            S_RST_HIGH: begin
               if (cnt_q == CNT_W'(RST_HIGH_CYC - 1)) begin // RL20
                  state_q <= S_RST_READY;
                  cnt_q <= '0;
               end
            end
            S_RST_READY: begin
               // busy may outlast the clear pulse; bounded so a stuck pin cannot hang us
               if (ready_busy_n || cnt_q == CNT_W'(RST_READY_CYC)) begin // RL19
                  redo_q <= 1'b0;
                  step_q <= 3'h0;
                  state_q <= redo_q ? S_ISSUE : S_IDLE; // RL18
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // user handshake and result
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         req_ready_q <= 1'b1;
         resp_valid_q <= 1'b0;
         resp_data_q <= '0;
      end else begin
         resp_valid_q <= 1'b0;
         if (state_q == S_IDLE && req_valid) req_ready_q <= 1'b0;
         if ((state_q == S_WAIT_CYC && cyc_done && st_last && !waits_busy) ||
             (state_q == S_BUSY && !abort_req && ready_busy_n) ||
             (state_q == S_RST_READY && !redo_q && (ready_busy_n || cnt_q == CNT_W'(RST_READY_CYC)))) begin
            resp_valid_q <= 1'b1;
            req_ready_q <= 1'b1;
         end
         if (state_q == S_WAIT_CYC && cyc_done && st_rd) resp_data_q <= cyc_rdata;
      end
   end

   // control pins; high-voltage enables last for the whole operation when it is accepted after resp_valid_q drops
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         width_select_n_q <= 1'b1;
         device_clear_n_q <= 1'b1;
         clear_vid_en_q <= 1'b0;
         hv_pin_en_q <= 1'b0;
      end else begin
         if (state_q == S_IDLE && req_valid) begin
            width_select_n_q <= ~req_byte; // RL4 RL5
            clear_vid_en_q <= (req_op == OP_PROTECT); // RL22
            hv_pin_en_q <= (req_op == OP_HV_ID); // RL16
         end
         if ((state_q == S_IDLE && req_valid && req_op == OP_RESET) || (state_q == S_BUSY && abort_req)) begin
            device_clear_n_q <= 1'b0;
         end else if (state_q == S_RST_LOW && cnt_q == CNT_W'(RST_LOW_CYC - 1)) begin
            device_clear_n_q <= 1'b1;
         end
         if (resp_valid_q) begin
            clear_vid_en_q <= 1'b0;
            hv_pin_en_q <= 1'b0;
         end
      end
   end

   flb_cycle u_cycle (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(start_q),
      .wr(~st_rd),
      .byte_mode(~width_select_n_q),
      .addr(st_addr),
      .wdata(st_data),
      .done_q(cyc_done),
      .rdata_q(cyc_rdata),
      .addr_q(flash_addr),
      .dq_o_q(dq_o),
      .dq_oe_q(dq_oe),
      .dq_i(dq_i),
      .cs_n_q(chip_select_n),
      .oe_n_q(output_gate_n),
      .we_n_q(write_strobe_n)
   );

   // helpers watched only by the checks below
   logic [7:0] low_cnt_q;
   logic [7:0] high_cnt_q;
   logic [2:0] wr_cnt_q;
   logic we_n_prev_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         low_cnt_q <= 8'h00;
         high_cnt_q <= HIGH_CNT_RST;
         wr_cnt_q <= 3'h0;
         we_n_prev_q <= 1'b1;
      end else begin
         we_n_prev_q <= write_strobe_n;
         low_cnt_q <= device_clear_n_q ? 8'h00 : low_cnt_q + 8'h01;
         high_cnt_q <= !device_clear_n_q ? 8'h00 : (high_cnt_q == HIGH_CNT_RST ? high_cnt_q : high_cnt_q + 8'h01);
         if (req_ready_q || !device_clear_n_q) wr_cnt_q <= 3'h0;
         else if (we_n_prev_q && !write_strobe_n) wr_cnt_q <= wr_cnt_q + 3'h1;
      end
   end

   clear_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) // RL17
      $rose(device_clear_n_q) |-> low_cnt_q >= 8'(RST_LOW_CYC)) else $error("clear pulse shorter than minimum");
   no_cycle_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RL17
      !device_clear_n_q |-> chip_select_n) else $error("bus cycle while clear is low");
   read_release_a: assert property (@(posedge ref_clk) disable iff (rst) // RL20
      $fell(chip_select_n) |-> high_cnt_q >= 8'(RST_HIGH_CYC)) else $error("access too soon after clear release");
   prog_writes_a: assert property (@(posedge ref_clk) disable iff (rst) // RL12
      resp_valid_q && op_q == OP_PROG |-> wr_cnt_q == PROG_WRITES) else $error("program did not use four writes");
   bypass_writes_a: assert property (@(posedge ref_clk) disable iff (rst) // RL13
      resp_valid_q && op_q == OP_BYP_PROG |-> wr_cnt_q == BYP_WRITES) else $error("bypass program not two writes");
   protect_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // RL22
      clear_vid_en_q && !chip_select_n |-> !flash_addr[PROT_SEL_BIT] && flash_addr[PROT_A1_BIT] &&
      !flash_addr[PROT_A0_BIT]) else $error("protect select address wrong");
   busy_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RL19
      state_q == S_RST_READY && !ready_busy_n && cnt_q < CNT_W'(RST_READY_CYC) |=> !resp_valid_q)
      else $error("finished while device still busy");
   redo_reissue_a: assert property (@(posedge ref_clk) disable iff (rst) // RL18
      state_q == S_BUSY && abort_req |-> ##1 !device_clear_n_q ##[1:900] state_q == S_ISSUE)
      else $error("interrupted operation not reissued");
endmodule : flb_host

// *** dv/flb_flash_model.sv ***
/*
 Behavioural flash device for the host bench: 64-word array, program, busy, clear.
 Assumes host pins change on ref_clk edges.
*/
module flb_flash_model #(
   parameter logic [15:0] PROG_CODE = 16'h0003,
   parameter int BUSY_CYC = 20
) (
   // system
   input wire logic ref_clk,
   // bus pins
   input wire logic [18:0] addr,
   input wire logic [15:0] dq_o,
   output logic [15:0] dq_i,
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic width_n,
   input wire logic clear_n,
   output logic ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [64];
   logic [15:0] last_q;
   logic [15:0] pd_q;
   logic [5:0] pa_q;
   logic setup_q;
   logic pv_q;
   logic we_prev_q = 1'b1;
   int busy_q = 0;
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = {8'hA5, 8'(i)};
   end
   // released bus shows inverse of last value, not a held copy
   always_comb begin
      dq_i = ~last_q;
      if (!cs_n && !oe_n && we_n && clear_n) begin
         if (width_n) dq_i = mem[addr[5:0]];
         else dq_i = {~last_q[15:8], dq_o[15] ? mem[addr[5:0]][15:8] : mem[addr[5:0]][7:0]};
      end
   end
   assign ready_busy_n = (busy_q == 0);
   always @(posedge ref_clk) begin
      last_q <= dq_i;
      we_prev_q <= we_n;
      if (!clear_n) begin
         setup_q <= 1'b0;
         pv_q <= 1'b0;
         if (busy_q > 0) busy_q <= BUSY_CYC;
      end else if (busy_q > 0) begin
         busy_q <= busy_q - 1;
         if (busy_q == 1 && pv_q) mem[pa_q] <= pd_q;
      end else if (!cs_n && we_n && !we_prev_q) begin
         if (setup_q) begin
            pa_q <= addr[5:0];
            pd_q <= dq_o;
            pv_q <= (addr[5:0] != 6'h3F); // top word acts as a protected sector
            busy_q <= BUSY_CYC;
            setup_q <= 1'b0;
         end else setup_q <= (dq_o == PROG_CODE);
      end
   end
endmodule : flb_flash_model

// *** dv/flb_host_tb.sv ***
/*
 Self-checking bench for flb_host against the flash model.
 Assumes flb_host parameter defaults for command codes.
*/
module flb_host_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flb_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   flb_op_e req_op = OP_READ;
   logic [19:0] req_addr = 20'h00000;
   logic [15:0] req_data = 16'h0000;
   logic req_byte = 1'b0;
   logic abort_req = 1'b0;
   logic req_ready_q, resp_valid_q, chip_select_n, output_gate_n, write_strobe_n;
   logic width_select_n_q, device_clear_n_q, clear_vid_en_q, hv_pin_en_q, ready_busy_n;
   logic [15:0] resp_data_q, dq_o, dq_oe, dq_i, r;
   logic [18:0] flash_addr, prot_a;
   logic [6:0] hi_oe;
   logic wmode, hv_seen, we_prev = 1'b1;
   int num_errors = 0, cmp_count = 0, wr_cnt = 0, clr_cnt = 0, cyc = 0, w0, c0;
   always #12.5 ref_clk = ~ref_clk;
   flb_host #(.PROT_PULSE_CYC(8)) dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .req_byte(req_byte), .abort_req(abort_req),
      .req_ready_q(req_ready_q), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
      .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .chip_select_n(chip_select_n),
      .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .width_select_n_q(width_select_n_q),
      .device_clear_n_q(device_clear_n_q), .clear_vid_en_q(clear_vid_en_q), .hv_pin_en_q(hv_pin_en_q),
      .ready_busy_n(ready_busy_n));
   flb_flash_model flash (.ref_clk(ref_clk), .addr(flash_addr), .dq_o(dq_o), .dq_i(dq_i),
      .cs_n(chip_select_n), .oe_n(output_gate_n), .we_n(write_strobe_n), .width_n(width_select_n_q),
      .clear_n(device_clear_n_q), .ready_busy_n(ready_busy_n));
   always @(posedge ref_clk) begin
      we_prev <= write_strobe_n;
      if (we_prev && !write_strobe_n) wr_cnt <= wr_cnt + 1;
      if (!device_clear_n_q) clr_cnt <= clr_cnt + 1;
      if (!output_gate_n) wmode <= width_select_n_q;
      if (!output_gate_n) hi_oe <= dq_oe[14:8];
      if (!output_gate_n) hv_seen <= hv_pin_en_q;
      if (clear_vid_en_q && !write_strobe_n) prot_a <= flash_addr;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic do_op(input flb_op_e op, input logic [19:0] a, input logic [15:0] d, input logic b);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (req_ready_q !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      req_byte <= b;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      while (resp_valid_q !== 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 3000) num_errors++;
      r = resp_data_q;
   endtask : do_op
   task automatic t_prog(input flb_op_e op, input logic [19:0] a, input logic [15:0] d, input int nw);
      w0 = wr_cnt;
      do_op(op, a, d, 1'b0);
      chk(16'(wr_cnt - w0), 16'(nw));
      do_op(OP_READ, a, 16'h0000, 1'b0);
      chk(r, d);
      $display("program test done");
   endtask : t_prog
   task automatic t_modes();
      w0 = wr_cnt;
      do_op(OP_CMD, 20'h00001, 16'h0055, 1'b0);
      do_op(OP_SECT_ERASE, 20'h00010, 16'h0000, 1'b0);
      do_op(OP_CHIP_ERASE, 20'h00000, 16'h0000, 1'b0);
      chk(16'(wr_cnt - w0), 16'h000D);
      w0 = wr_cnt;
      do_op(OP_AUTOSEL, 20'h00005, 16'h0000, 1'b0);
      chk(16'(wr_cnt - w0), 16'h0003);
      do_op(OP_HV_ID, 20'h00005, 16'h0000, 1'b0);
      chk({15'h0, hv_seen}, 16'h0001);
      chk(r, 16'hA505);
      do_op(OP_PROG, 20'h0003F, 16'h1111, 1'b0);
      do_op(OP_READ, 20'h0003F, 16'h0000, 1'b0);
      chk(r, 16'hA53F);
      $display("mode test done");
   endtask : t_modes
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      do_op(OP_READ, 20'h00005, 16'h0000, 1'b0);
      chk(r, 16'hA505);
      chk({15'h0, wmode}, 16'h0001);
      do_op(OP_READ, 20'h00009, 16'h0000, 1'b1);
      chk(r, 16'h00A5);
      chk({15'h0, wmode}, 16'h0000);
      chk({9'h0, hi_oe}, 16'h0000);
      $display("read test done");
      t_prog(OP_PROG, 20'h00003, 16'h1234, 4);
      do_op(OP_BYP_ENTER, 20'h00000, 16'h0000, 1'b0);
      t_prog(OP_BYP_PROG, 20'h00007, 16'hBEEF, 2);
      do_op(OP_BYP_EXIT, 20'h00000, 16'h0000, 1'b0);
      c0 = clr_cnt;
      do_op(OP_RESET, 20'h00000, 16'h0000, 1'b0);
      chk(16'(clr_cnt - c0 >= RST_LOW_CYC), 16'h0001);
      do_op(OP_READ, 20'h00003, 16'h0000, 1'b0);
      chk(r, 16'h1234);
      $display("reset test done");
      w0 = wr_cnt;
      fork
         do_op(OP_PROG, 20'h0000A, 16'h5A5A, 1'b0);
         begin
            @(negedge ref_clk);
            while (ready_busy_n !== 1'b0) @(negedge ref_clk);
            @(posedge ref_clk);
            abort_req <= 1'b1;
            // held until the clear pin answers: ignored before the busy wait
            while (device_clear_n_q !== 1'b0) @(negedge ref_clk);
            @(posedge ref_clk);
            abort_req <= 1'b0;
         end
      join
      chk(16'(wr_cnt - w0), 16'h0008);
      do_op(OP_READ, 20'h0000A, 16'h0000, 1'b0);
      chk(r, 16'h5A5A);
      $display("abort test done");
      t_modes();
      do_op(OP_PROTECT, 20'h7FFFF, 16'h0000, 1'b0);
      chk({13'h0, prot_a[6], prot_a[1], prot_a[0]}, 16'h0002);
      $display("protect test done");
      finish_test();
   end
endmodule : flb_host_tb
